// *** src/cpc_pkg.sv ***
// Shared constants and types of the companding codec
package cpc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int LIN_W  = 14;
    localparam int CODE_W = 8;

    typedef logic signed [LIN_W-1:0] cpc_lin_t;
    typedef logic [CODE_W-1:0]       cpc_code_t;
    typedef logic [6:0]              cpc_num_t;

    // ------------------------------------------------------------
    // Law selection
    // ------------------------------------------------------------
    typedef enum logic {
        CPC_LAW_A  = 1'b0,
        CPC_LAW_MU = 1'b1
    } cpc_law_t;

    // ------------------------------------------------------------
    // Scale and code constants
    // ------------------------------------------------------------
    localparam logic [LIN_W-1:0]  CPC_A_FULL     = 14'h1000;
    localparam logic [LIN_W-1:0]  CPC_MU_FULL    = 14'h1fdf;
    localparam logic [LIN_W:0]    CPC_MU_BIAS    = 15'h0021;
    localparam cpc_code_t         CPC_A_EVEN_INV = 8'h55;
    localparam cpc_num_t          CPC_NUM_MAX    = 7'h7f;
    localparam int                CPC_SIGN_BIT   = 7;
    localparam logic [3:0]        CPC_A_SEG0_MSB = 4'h5;
    localparam logic [3:0]        CPC_A_SEG_OFS  = 4'h4;
    localparam logic [3:0]        CPC_MU_SEG_OFS = 4'h5;

endpackage

// *** src/cpc_dec_if.sv ***
// Carrier between the codec top and its decoder core
`timescale 1ns/1ps
interface cpc_dec_if;
    import cpc_pkg::*;
    cpc_law_t  law;
    cpc_code_t code;
    cpc_lin_t  lin;

    modport dec  (input law, input code, output lin);
    modport user (output law, output code, input lin);
endinterface

// *** src/cpc_pcm_decoder.sv ***
// PCM character to linear sample decoder core
`timescale 1ns/1ps
module cpc_pcm_decoder
    import cpc_pkg::*;
(
    cpc_dec_if.dec dec
);

    // ------------------------------------------------------------
    // Reconstruction at interval midpoints, mu-law zero code to zero
    // ------------------------------------------------------------
    cpc_code_t         plain;
    cpc_num_t          num;
    logic [2:0]        grp;
    logic [LIN_W-1:0]  mag;
    logic [LIN_W-1:0]  base;

    always_comb begin
        plain = dec.code;
        num   = '0;
        mag   = '0;
        base  = '0;
        if (dec.law == CPC_LAW_A) begin
            plain = dec.code ^ CPC_A_EVEN_INV;               // see R2
            num   = plain[6:0];
        end else begin
            num   = ~dec.code[6:0];
        end
        grp  = num[6:4];
        base = LIN_W'({1'b1, num[3:0]});
        if (dec.law == CPC_LAW_A) begin
            if (grp == 3'h0) begin
                mag = LIN_W'({num, 1'b1});                   // see R4
            end else begin
                mag = (base << grp) + (LIN_W'(1) << (grp - 3'h1)); // see R4
            end
        end else begin
            if (num == '0) begin
                mag = '0;                                    // see R6
            end else begin
                mag = (base << ({1'b0, grp} + 4'h1)) - LIN_W'(CPC_MU_BIAS)
                    + (LIN_W'(1) << grp);                    // see R6
            end
        end
        dec.lin = plain[CPC_SIGN_BIT] ? cpc_lin_t'(mag) : -cpc_lin_t'(mag); // see R3
    end

endmodule

// *** src/cpc_codec.sv ***
// A-law / mu-law companding codec, encoder and decoder paths
// ------------------------------------------------------------
// Summary of operation
// R1 - A-law positive code is 128 plus n
// R2 - A-law even bits inverted, decoder undoes
// R3 - First bit: 0 negative, 1 positive
// R4 - A-law decode outputs decision interval midpoint
// R5 - Mu-law positive code 255 minus n, zero all ones
// R6 - Mu-law decode zero, else interval midpoint
// R7 - A-law scale spans 4096 units
// R8 - Mu-law scale spans 8159 units
// R9 - Above decision 127 maps to top code
// R10 - Exact decision value starts its interval
// R11 - Full scale or more saturates, sign kept
// ------------------------------------------------------------
`timescale 1ns/1ps
module cpc_codec
    import cpc_pkg::*;
(
    // Clock and reset
    input  wire logic      mclk,
    input  wire logic      rstn,
    // Law selection
    input  wire cpc_law_t  law,
    // Linear to PCM
    input  wire logic      enc_valid,
    input  wire cpc_lin_t  enc_lin,
    output logic           pcm_valid,
    output cpc_code_t      pcm_out,
    // PCM to linear
    input  wire logic      dec_valid,
    input  wire cpc_code_t dec_pcm,
    output logic           lin_valid,
    output cpc_lin_t       lin_out
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] msb_pos(input logic [LIN_W:0] v);
        logic [3:0] p;
        p = '0;
        for (int i = 0; i <= LIN_W; i++) begin
            if (v[i]) begin
                p = 4'(i);
            end
        end
        return p;
    endfunction

    // ------------------------------------------------------------
    // Encoder
    // ------------------------------------------------------------
    logic              neg;
    logic [LIN_W-1:0]  mag;
    logic [LIN_W:0]    biased;
    logic [3:0]        pos;
    logic [3:0]        sh;
    cpc_num_t          num;
    cpc_code_t         code;

    always_comb begin
        neg    = enc_lin[LIN_W-1];
        mag    = neg ? LIN_W'(-enc_lin) : LIN_W'(enc_lin);
        biased = '0;
        pos    = '0;
        sh     = '0;
        num    = '0;
        if (law == CPC_LAW_A) begin
            pos = msb_pos({1'b0, mag});
            if (mag >= CPC_A_FULL) begin
                num = CPC_NUM_MAX;                           // see R7 R9 R11
            end else if (pos <= CPC_A_SEG0_MSB) begin
                num = mag[6:0] >> 1;                         // see R10
            end else begin
                sh  = pos - CPC_A_SEG_OFS;
                num = {sh[2:0], 4'(mag >> sh)};              // see R1 R10
            end
            code = {~neg, num} ^ CPC_A_EVEN_INV;             // see R1 R2 R3
        end else begin
            biased = {1'b0, mag} + CPC_MU_BIAS;
            pos    = msb_pos(biased);
            if (mag >= CPC_MU_FULL) begin
                num = CPC_NUM_MAX;                           // see R8 R9 R11
            end else begin
                sh  = pos - CPC_A_SEG_OFS;
                num = {3'(pos - CPC_MU_SEG_OFS), 4'(biased >> sh)}; // see R10
            end
            code = {~neg, ~num};                             // see R3 R5
        end
    end

    // ------------------------------------------------------------
    // Decoder core
    // ------------------------------------------------------------
    cpc_dec_if dif ();

    assign dif.law  = law;
    assign dif.code = dec_pcm;

    cpc_pcm_decoder u_dec (
        .dec (dif.dec)
    );

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    logic      pcm_valid_d;
    logic      pcm_valid_q;
    cpc_code_t pcm_out_d;
    cpc_code_t pcm_out_q;
    logic      lin_valid_d;
    logic      lin_valid_q;
    cpc_lin_t  lin_out_d;
    cpc_lin_t  lin_out_q;

    always_comb begin
        pcm_valid_d = enc_valid;
        pcm_out_d   = enc_valid ? code : pcm_out_q;
        lin_valid_d = dec_valid;
        lin_out_d   = dec_valid ? dif.lin : lin_out_q;       // see R4 R6
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pcm_valid_q <= 1'b0;
            pcm_out_q   <= '0;
            lin_valid_q <= 1'b0;
            lin_out_q   <= '0;
        end else begin
            pcm_valid_q <= pcm_valid_d;
            pcm_out_q   <= pcm_out_d;
            lin_valid_q <= lin_valid_d;
            lin_out_q   <= lin_out_d;
        end
    end

    assign pcm_valid = pcm_valid_q;
    assign pcm_out   = pcm_out_q;
    assign lin_valid = lin_valid_q;
    assign lin_out   = lin_out_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_a_code_2048: assert property ( // see R1
        enc_valid && law == CPC_LAW_A && enc_lin == 14'sd2048 |=> pcm_valid && pcm_out == 8'ha5)
        else $error("A-law code for 2048 wrong");

    a_a_zero_inv: assert property ( // see R2
        enc_valid && law == CPC_LAW_A && enc_lin == 14'sd0 |=> pcm_out == 8'hd5)
        else $error("A-law zero not even-bit inverted");

    a_sign_bit: assert property ( // see R3
        enc_valid |=> pcm_out[7] == !$past(enc_lin[13]))
        else $error("Sign bit does not follow input sign");

    a_a_dec_mid: assert property ( // see R4
        dec_valid && law == CPC_LAW_A && dec_pcm == 8'ha5 |=> lin_valid && lin_out == 14'sd2112)
        else $error("A-law decode midpoint wrong");

    a_mu_zero_ones: assert property ( // see R5
        enc_valid && law == CPC_LAW_MU && enc_lin == 14'sd0 |=> pcm_out == 8'hff)
        else $error("Mu-law zero is not all ones");

    a_mu_dec_zero: assert property ( // see R6
        dec_valid && law == CPC_LAW_MU && dec_pcm == 8'hff |=> lin_valid && lin_out == 14'sd0)
        else $error("Mu-law decode of zero code not zero");

    a_mu_dec_mid: assert property ( // see R6
        dec_valid && law == CPC_LAW_MU && dec_pcm == 8'h9f |=> lin_out == 14'sd2079)
        else $error("Mu-law decode midpoint wrong");

    a_a_top_seg: assert property ( // see R7 R9
        enc_valid && law == CPC_LAW_A && enc_lin >= 14'sd3968 |=> pcm_out == 8'haa)
        else $error("A-law top interval not top code");

    a_mu_sat_neg: assert property ( // see R8 R11
        enc_valid && law == CPC_LAW_MU && enc_lin <= -14'sd8159 |=> pcm_out == 8'h00)
        else $error("Mu-law negative saturation wrong");

    a_edge_split: assert property ( // see R10
        enc_valid && law == CPC_LAW_A && enc_lin == 14'sd3967 |=> pcm_out == 8'hab)
        else $error("A-law decision edge misplaced");

    a_valid_lat: assert property ( // see R1
        enc_valid |=> pcm_valid)
        else $error("Encoder answer not one cycle later");

    a_dec_lat: assert property ( // see R4
        dec_valid |=> lin_valid)
        else $error("Decoder answer not one cycle later");

    a_enc_idle: assert property ( // see R1
        !enc_valid |=> !pcm_valid)
        else $error("Character valid without a request");

    a_dec_idle: assert property ( // see R4
        !dec_valid |=> !lin_valid)
        else $error("Sample valid without a request");

    a_mu_code_seg: assert property ( // see R5
        enc_valid && law == CPC_LAW_MU && enc_lin == 14'sd2015 |=> pcm_out == 8'h9f)
        else $error("Mu-law code for 2015 wrong");

    a_mu_sat_pos: assert property ( // see R8 R11
        enc_valid && law == CPC_LAW_MU && enc_lin >= 14'sd8159 |=> pcm_out == 8'h80)
        else $error("Mu-law positive saturation wrong");

    a_a_sat_neg: assert property ( // see R7 R11
        enc_valid && law == CPC_LAW_A && enc_lin <= -14'sd4096 |=> pcm_out == 8'h2a)
        else $error("A-law negative saturation wrong");

    c_a_enc:   cover property (enc_valid && law == CPC_LAW_A);
    c_mu_dec:  cover property (dec_valid && law == CPC_LAW_MU);
    c_mu_enc:  cover property (enc_valid && law == CPC_LAW_MU && enc_lin[13]);
    c_dec_b2b: cover property (dec_valid ##1 dec_valid);
    c_both:    cover property (enc_valid && dec_valid);

endmodule

// *** tb/cpc_far_model.sv ***
// Far-side sink: counter of characters and samples
`timescale 1ns/1ps
module cpc_far_model (
    // Clock
    input  wire logic mclk,
    // Streams from the codec
    input  wire logic pcm_valid,
    input  wire logic lin_valid,
    // Item counts
    output int        n_pcm,
    output int        n_lin
);
    // Never stalls, so counts every character and sample
    always @(posedge mclk) begin
        if (pcm_valid === 1'b1) begin
            n_pcm <= n_pcm + 1;
        end
        if (lin_valid === 1'b1) begin
            n_lin <= n_lin + 1;
        end
    end
endmodule

// *** tb/pcm_companding_codec_bench.sv ***
// Self-checking bench of the companding codec
`timescale 1ns/1ps
module pcm_companding_codec_bench;
    import cpc_pkg::*;
    typedef struct { cpc_law_t l; logic d; int v; int e; } cpc_row_t;
    logic      mclk = 1'b0, rstn = 1'b0, enc_valid = 1'b0, dec_valid = 1'b0;
    logic      pcm_valid, lin_valid, pend_e = 1'b0, pend_d = 1'b0;
    cpc_law_t  law = CPC_LAW_A, lw;
    cpc_lin_t  enc_lin = '0, lin_out, exp_l = '0;
    cpc_code_t dec_pcm = '0, pcm_out, exp_c = '0;
    int        miscompares = 0, num_checks = 0, n_enc = 0, n_dec = 0, cyc = 0, n_pcm, n_lin, xa, xb;
    cpc_row_t  rows[17] = '{
        '{CPC_LAW_MU, 0, 0, 'hff}, '{CPC_LAW_A, 0, 0, 'hd5}, '{CPC_LAW_A, 0, 2048, 'ha5},
        '{CPC_LAW_A, 0, 2047, 'hba}, '{CPC_LAW_A, 0, 4095, 'haa}, '{CPC_LAW_A, 0, 4096, 'haa},
        '{CPC_LAW_A, 0, -8192, 'h2a}, '{CPC_LAW_MU, 0, 8159, 'h80}, '{CPC_LAW_MU, 0, -8159, 'h00},
        '{CPC_LAW_MU, 0, -1, 'h7e}, '{CPC_LAW_A, 1, 'ha5, 2112}, '{CPC_LAW_A, 1, 'haa, 4032},
        '{CPC_LAW_MU, 1, 'hff, 0}, '{CPC_LAW_MU, 1, 'h7f, 0}, '{CPC_LAW_MU, 1, 'h80, 8031},
        '{CPC_LAW_A, 1, 'h2a, -4032}, '{CPC_LAW_A, 0, 3967, 'hab}};

    cpc_codec uut (.mclk(mclk), .rstn(rstn), .law(law), .enc_valid(enc_valid), .enc_lin(enc_lin),
        .pcm_valid(pcm_valid), .pcm_out(pcm_out), .dec_valid(dec_valid), .dec_pcm(dec_pcm),
        .lin_valid(lin_valid), .lin_out(lin_out));
    cpc_far_model far (.mclk(mclk), .pcm_valid(pcm_valid), .lin_valid(lin_valid), .n_pcm(n_pcm),
        .n_lin(n_lin));

    always #4 mclk = ~mclk;

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic int xv(cpc_law_t l, int n);
        int s;
        s = n >> 4;
        if (l == CPC_LAW_A) return (n < 32) ? 2 * n : (1 << (s + 4)) + ((n & 15) << s);
        return (n < 16) ? ((n == 0) ? 0 : 2 * n - 1) : (1 << (s + 5)) - 33 + ((n & 15) << (s + 1));
    endfunction

    function automatic cpc_code_t enc_m(cpc_law_t l, int v);
        int m, n;
        m = (v < 0) ? -v : v;
        n = 0;
        for (int k = 1; k < 128; k++) begin
            if (xv(l, k) <= m) n = k;
        end
        return (l == CPC_LAW_A) ? {v >= 0, n[6:0]} ^ CPC_A_EVEN_INV : {v >= 0, ~n[6:0]};
    endfunction

    function automatic cpc_lin_t dec_m(cpc_law_t l, cpc_code_t c);
        int n, y;
        n = (l == CPC_LAW_A) ? int'((c ^ CPC_A_EVEN_INV) & 8'h7f) : int'(~c & 8'h7f);
        y = (l == CPC_LAW_MU && n == 0) ? 0 : (xv(l, n) + xv(l, n + 1)) / 2;
        return c[7] ? cpc_lin_t'(y) : cpc_lin_t'(-y);
    endfunction

    // ------------------------------------------------------------
    // Compares, stepping and reset
    // ------------------------------------------------------------
    task automatic chk_bit(string s, logic e, logic g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", s, e, g);
        end
    endtask

    task automatic chk_code(string s, cpc_code_t e, cpc_code_t g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic chk_lin(string s, cpc_lin_t e, cpc_lin_t g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %0d seen %0d", s, e, g);
        end
    endtask

    task automatic chk_cnt(string s, int e, int g);
        num_checks++;
        if (g != e) begin
            miscompares++;
            $display("BAD %s expected %0d seen %0d", s, e, g);
        end
    endtask

    // Up to one encode and one decode request per cycle; checks the answers to the previous ones
    task automatic step(cpc_law_t l, logic ev, int v, cpc_code_t ec, logic dv, cpc_code_t c, cpc_lin_t el);
        @(posedge mclk);
        law <= l;
        enc_valid <= ev;
        enc_lin <= cpc_lin_t'(v);
        dec_valid <= dv;
        dec_pcm <= c;
        #1;
        chk_bit("pcm_valid", pend_e, pcm_valid);
        chk_code("pcm_out", exp_c, pcm_out);
        chk_bit("lin_valid", pend_d, lin_valid);
        chk_lin("lin_out", exp_l, lin_out);
        pend_e = ev;
        pend_d = dv;
        if (ev) exp_c = ec;
        if (dv) exp_l = el;
        n_enc += int'(ev);
        n_dec += int'(dv);
    endtask

    task automatic do_reset(int n);
        @(posedge mclk);
        rstn <= 1'b0;
        enc_valid <= 1'b0;
        dec_valid <= 1'b0;
        #1;
        chk_bit("pcm_valid in flight", pend_e, pcm_valid);
        chk_code("pcm_out in flight", exp_c, pcm_out);
        chk_bit("lin_valid in flight", pend_d, lin_valid);
        chk_lin("lin_out in flight", exp_l, lin_out);
        repeat (n) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        pend_e = 1'b0;
        pend_d = 1'b0;
        exp_c = '0;
        exp_l = '0;
        chk_bit("pcm_valid rst", 1'b0, pcm_valid);
        chk_code("pcm_out rst", exp_c, pcm_out);
        chk_bit("lin_valid rst", 1'b0, lin_valid);
        chk_lin("lin_out rst", exp_l, lin_out);
    endtask

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset(8);
        foreach (rows[i]) begin
            step(rows[i].l, !rows[i].d, rows[i].v, 8'(rows[i].e), rows[i].d, 8'(rows[i].v), 14'(rows[i].e));
        end
        step(CPC_LAW_A, 1'b0, 0, '0, 1'b0, '0, '0);
        step(CPC_LAW_A, 1'b0, 0, '0, 1'b0, '0, '0);
        // Every decision boundary, the negated value just below the next one, every character
        for (int l = 0; l < 2; l++) begin
            for (int n = 0; n < 128; n++) begin
                lw = cpc_law_t'(l);
                xa = xv(lw, n);
                xb = 1 - xv(lw, n + 1);
                step(lw, 1'b1, xa, enc_m(lw, xa), 1'b1, 8'(n), dec_m(lw, 8'(n)));
                step(lw, 1'b1, xb, enc_m(lw, xb), 1'b1, 8'(n + 128), dec_m(lw, 8'(n + 128)));
            end
        end
        // Request in flight when reset hits
        step(CPC_LAW_MU, 1'b1, 100, 8'hdf, 1'b1, 8'h55, -14'sd179);
        do_reset(2);
        step(CPC_LAW_MU, 1'b1, 8158, 8'h80, 1'b1, 8'h80, 14'h1f5f);
        step(CPC_LAW_A, 1'b0, 0, '0, 1'b0, '0, '0);
        step(CPC_LAW_A, 1'b0, 0, '0, 1'b0, '0, '0);
        chk_cnt("pcm count", n_enc, n_pcm);
        chk_cnt("lin count", n_dec, n_lin);
        end_of_test;
    end
endmodule
